// >>> hdl/upc_port_one_control.sv
// port-one control register with power enable and init state outputs
`include "upc_map.svh"
module upc_port_one_control (
	input wire logic clock,
	input wire logic reset,
	input wire upc_pkg::upc_bus_req_type busReq,
	output logic [`UPC_DATA_W-1:0] readData,
	output upc_pkg::upc_port_out_type portOut
);
	logic [`UPC_DATA_W-1:0] ctrl_ff;
	logic [`UPC_DATA_W-1:0] nxt_ctrl;
	logic [`UPC_DATA_W-1:0] clearedWord;
	wire logic addrHit;
	wire logic writeHit;
	wire logic readHit;
	wire logic readMiss;
	wire logic initClearReq;
	wire logic [1:0] powerField;

	// address decode
	assign addrHit = busReq.addr == `UPC_CTRL_OFFSET;
	assign writeHit = busReq.wr & addrHit;
	assign readHit = busReq.rd & addrHit;
	assign readMiss = busReq.rd & ~addrHit;

	// the init-clear bit is self-clearing and takes the init state with it
	assign initClearReq = busReq.wdata[`UPC_INIT_CLEAR_BIT];

	always_comb begin
		clearedWord = busReq.wdata;
		if (initClearReq) begin
			clearedWord[`UPC_INIT_CLEAR_BIT] = 1'b0;
			clearedWord[`UPC_INIT_STATE_BIT] = 1'b0;
		end
	end

	// reserved bits are stored as written; software keeps them at reset value
	assign nxt_ctrl = writeHit ? clearedWord : ctrl_ff;

	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl_ff <= `UPC_CTRL_RESET;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	assign powerField = ctrl_ff[`UPC_POWER_MSB:`UPC_POWER_LSB];

	// only the full 11b pattern powers the port; a half-written field stays off
	assign portOut.powerEnable = powerField == `UPC_POWER_ON;
	// init state drives the port 1 transceiver only, ports 2 and 3 never see it
	assign portOut.initState = ctrl_ff[`UPC_INIT_STATE_BIT];

	upc_read_port readPort (
		.clock(clock),
		.reset(reset),
		.readHit(readHit),
		.readMiss(readMiss),
		.ctrlValue(ctrl_ff),
		.readData(readData)
	);

	// assertions
	a_init_clear_both: assert property (@(posedge clock) disable iff (reset)
		writeHit && busReq.wdata[`UPC_INIT_CLEAR_BIT]
		|=> !ctrl_ff[`UPC_INIT_CLEAR_BIT] && !ctrl_ff[`UPC_INIT_STATE_BIT])
		else $error("init clear write left an init bit set");

	a_plain_write_stores: assert property (@(posedge clock) disable iff (reset)
		writeHit && !busReq.wdata[`UPC_INIT_CLEAR_BIT]
		|=> ctrl_ff == $past(busReq.wdata))
		else $error("write without init clear not stored as written");

	a_power_on_write: assert property (@(posedge clock) disable iff (reset)
		writeHit && busReq.wdata[`UPC_POWER_MSB:`UPC_POWER_LSB] == `UPC_POWER_ON
		|=> portOut.powerEnable)
		else $error("power field 11b did not enable port power");

	a_power_off_write: assert property (@(posedge clock) disable iff (reset)
		writeHit && busReq.wdata[`UPC_POWER_MSB:`UPC_POWER_LSB] != `UPC_POWER_ON
		|=> !portOut.powerEnable)
		else $error("port power enabled without field 11b");

	a_init_word_effect: assert property (@(posedge clock) disable iff (reset)
		writeHit && busReq.wdata == `UPC_INIT_WORD
		|=> !portOut.initState && portOut.powerEnable)
		else $error("init word did not clear init state and power the port");

	a_reset_value: assert property (@(posedge clock) disable iff (reset)
		$fell(reset) |-> ctrl_ff == `UPC_CTRL_RESET && !portOut.powerEnable && readData == 32'h0000_0000)
		else $error("wrong value after reset");

	a_read_mirror: assert property (@(posedge clock) disable iff (reset)
		readHit |=> readData[`UPC_DATA_W-1:`UPC_HALF_W] == readData[`UPC_HALF_W-1:0])
		else $error("read halves differ");

	a_read_value: assert property (@(posedge clock) disable iff (reset)
		readHit |=> readData[`UPC_HALF_W-1:0]
			== ($past(ctrl_ff[`UPC_DATA_W-1:`UPC_HALF_W]) | $past(ctrl_ff[`UPC_HALF_W-1:0])))
		else $error("read data does not match register");

	a_unmapped_read: assert property (@(posedge clock) disable iff (reset)
		readMiss |=> readData == 32'h0000_0000)
		else $error("unmapped read not zero");

	a_hold_idle: assert property (@(posedge clock) disable iff (reset)
		!writeHit |=> $stable(ctrl_ff))
		else $error("register changed without a write");

	// port outputs are pure decodes of the stored word, so they may never run ahead of it
	a_power_follows_field: assert property (@(posedge clock) disable iff (reset)
		portOut.powerEnable == (powerField == `UPC_POWER_ON))
		else $error("power enable does not follow the power field");

	a_init_follows_bit: assert property (@(posedge clock) disable iff (reset)
		portOut.initState == ctrl_ff[`UPC_INIT_STATE_BIT])
		else $error("init state does not follow the stored bit");

	a_field_low_off: assert property (@(posedge clock) disable iff (reset)
		powerField != `UPC_POWER_ON |-> !portOut.powerEnable)
		else $error("power enabled with field not 11b");

	a_power_msb_only: assert property (@(posedge clock) disable iff (reset)
		writeHit && busReq.wdata[`UPC_POWER_MSB:`UPC_POWER_LSB] == 2'h2
		|=> !portOut.powerEnable)
		else $error("power enabled with field 10b");

	a_power_lsb_only: assert property (@(posedge clock) disable iff (reset)
		writeHit && busReq.wdata[`UPC_POWER_MSB:`UPC_POWER_LSB] == 2'h1
		|=> !portOut.powerEnable)
		else $error("power enabled with field 01b");

	a_power_none: assert property (@(posedge clock) disable iff (reset)
		writeHit && busReq.wdata[`UPC_POWER_MSB:`UPC_POWER_LSB] == 2'h0
		|=> !portOut.powerEnable)
		else $error("power enabled with field 00b");

	a_clear_bit_low: assert property (@(posedge clock) disable iff (reset)
		writeHit && busReq.wdata[`UPC_INIT_CLEAR_BIT]
		|=> !ctrl_ff[`UPC_INIT_CLEAR_BIT])
		else $error("init clear bit stayed set");

	a_state_bit_low: assert property (@(posedge clock) disable iff (reset)
		writeHit && busReq.wdata[`UPC_INIT_CLEAR_BIT]
		|=> !portOut.initState)
		else $error("init state stayed set after clear");

	a_clear_keeps_top: assert property (@(posedge clock) disable iff (reset)
		writeHit && busReq.wdata[`UPC_INIT_CLEAR_BIT]
		|=> ctrl_ff[31:24] == $past(busReq.wdata[31:24]))
		else $error("init clear disturbed bits 31 to 24");

	a_clear_keeps_mid: assert property (@(posedge clock) disable iff (reset)
		writeHit && busReq.wdata[`UPC_INIT_CLEAR_BIT]
		|=> ctrl_ff[22:8] == $past(busReq.wdata[22:8]))
		else $error("init clear disturbed bits 22 to 8");

	a_clear_keeps_low: assert property (@(posedge clock) disable iff (reset)
		writeHit && busReq.wdata[`UPC_INIT_CLEAR_BIT]
		|=> ctrl_ff[6:0] == $past(busReq.wdata[6:0]))
		else $error("init clear disturbed bits 6 to 0");

	a_init_word_stored: assert property (@(posedge clock) disable iff (reset)
		writeHit && busReq.wdata == `UPC_INIT_WORD
		|=> ctrl_ff == 32'h0000_0018)
		else $error("init word not stored with both init bits low");

	a_miss_write_ignored: assert property (@(posedge clock) disable iff (reset)
		busReq.wr && !addrHit |=> $stable(ctrl_ff))
		else $error("write to another address changed the register");

	a_read_no_change: assert property (@(posedge clock) disable iff (reset)
		readHit |=> $stable(ctrl_ff))
		else $error("read changed the register");

	a_read_holds: assert property (@(posedge clock) disable iff (reset)
		!busReq.rd |=> $stable(readData))
		else $error("read data changed without a read");

	a_read_upper_value: assert property (@(posedge clock) disable iff (reset)
		readHit |=> readData[`UPC_DATA_W-1:`UPC_HALF_W]
			== ($past(ctrl_ff[`UPC_DATA_W-1:`UPC_HALF_W]) | $past(ctrl_ff[`UPC_HALF_W-1:0])))
		else $error("upper read half does not match register");

	a_reset_init_state: assert property (@(posedge clock) disable iff (reset)
		$fell(reset) |-> !portOut.initState)
		else $error("init state set after reset");

	a_reset_clear_bit: assert property (@(posedge clock) disable iff (reset)
		$fell(reset) |-> ctrl_ff[`UPC_INIT_CLEAR_BIT])
		else $error("init clear bit not set after reset");

	a_reset_power_field: assert property (@(posedge clock) disable iff (reset)
		$fell(reset) |-> powerField == 2'h2)
		else $error("power field not 10b after reset");

	a_init_state_idle: assert property (@(posedge clock) disable iff (reset)
		!writeHit |=> $stable(portOut.initState))
		else $error("init state moved without a write");

	a_power_idle: assert property (@(posedge clock) disable iff (reset)
		!writeHit |=> $stable(portOut.powerEnable))
		else $error("power enable moved without a write");

	c_partial_field: cover property (@(posedge clock) disable iff (reset)
		writeHit && busReq.wdata[`UPC_POWER_MSB:`UPC_POWER_LSB] == 2'h1);
	c_miss_then_hit: cover property (@(posedge clock) disable iff (reset)
		readMiss ##[1:8] readHit);
	c_init_word: cover property (@(posedge clock) disable iff (reset)
		writeHit && busReq.wdata == `UPC_INIT_WORD ##1 readHit);
	c_power_off_again: cover property (@(posedge clock) disable iff (reset)
		portOut.powerEnable ##[1:20] !portOut.powerEnable);
	c_back_to_back: cover property (@(posedge clock) disable iff (reset)
		writeHit ##1 readHit ##1 writeHit);
endmodule // upc_port_one_control

// >>> hdl/upc_map.svh
// offsets, field positions and reset value of the port-one control register
`ifndef UPC_MAP_SVH
`define UPC_MAP_SVH
`define UPC_ADDR_W 16
`define UPC_DATA_W 32
`define UPC_HALF_W 16
`define UPC_CTRL_OFFSET 16'h0374
`define UPC_CTRL_RESET 32'h0086_0016
`define UPC_INIT_CLEAR_BIT 23
`define UPC_INIT_STATE_BIT 7
`define UPC_POWER_MSB 4
`define UPC_POWER_LSB 3
`define UPC_POWER_ON 2'h3
`define UPC_INIT_WORD 32'h0080_0018
`endif

// >>> hdl/upc_pkg.sv
// types shared by the port-one control block
package upc_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} upc_bus_req_type;
	typedef struct packed {
		logic powerEnable;
		logic initState;
	} upc_port_out_type;
endpackage

// >>> hdl/upc_read_port.sv
// registered read path with half-word mirroring
`include "upc_map.svh"
module upc_read_port (
	input wire logic clock,
	input wire logic reset,
	input wire logic readHit,
	input wire logic readMiss,
	input wire logic [`UPC_DATA_W-1:0] ctrlValue,
	output logic [`UPC_DATA_W-1:0] readData
);
	logic [`UPC_DATA_W-1:0] rdata_ff;
	logic [`UPC_DATA_W-1:0] nxt_rdata;
	wire logic [`UPC_HALF_W-1:0] mergedHalf;

	// both halves carry the OR of the upper and lower register halves, so a 16-bit host sees that merge on either half
	assign mergedHalf = ctrlValue[`UPC_DATA_W-1:`UPC_HALF_W] | ctrlValue[`UPC_HALF_W-1:0];
	assign nxt_rdata = readHit ? {mergedHalf, mergedHalf} : (readMiss ? 32'h0000_0000 : rdata_ff);

	always_ff @(posedge clock) begin
		if (reset) begin
			rdata_ff <= 32'h0000_0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign readData = rdata_ff;
endmodule // upc_read_port

// >>> sim/upc_host.sv
// host-side bus master model for the port-one control register
module upc_host (
	input wire logic clock,
	output upc_pkg::upc_bus_req_type busReq
);
	timeunit 1ns;
	timeprecision 1ps;
	initial busReq = '0;
	// one-cycle strobe; released fields go inverse so stale values never look valid
	task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] data);
		@(posedge clock);
		busReq <= '{addr: addr, wdata: data, wr: wr, rd: !wr};
		@(posedge clock);
		busReq <= '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
	endtask
endmodule // upc_host

// >>> sim/tb.sv
// self-checking bench for the port-one control register
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [31:0] readData;
	upc_pkg::upc_bus_req_type busReq;
	upc_pkg::upc_port_out_type portOut;
	int err_total = 0;
	int checks = 0;
	logic [31:0] model = 32'h0086_0016;
	logic [15:0] lfsr = 16'h0013;
	logic [31:0] d;
	always #5 clock = ~clock;
	upc_host host (.clock(clock), .busReq(busReq));
	upc_port_one_control DUT (.clock(clock), .reset(reset), .busReq(busReq), .readData(readData), .portOut(portOut));
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		host.access(1'b1, a, v);
		if (a == 16'h0374) model = v[23] ? (v & ~32'h0080_0080) : v;
	endtask
	// one read, then both outputs against the model
	task automatic check_all(input logic [15:0] a);
		host.access(1'b0, a, 32'h0000_0000);
		#1;
		cmp("readData", a == 16'h0374 ? {2{model[31:16] | model[15:0]}} : 32'h0000_0000, readData);
		cmp("powerEnable", {31'h0, model[4:3] == 2'h3}, {31'h0, portOut.powerEnable});
		cmp("initState", {31'h0, model[7]}, {31'h0, portOut.initState});
	endtask
	task automatic print_verdict();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#20000;
		err_total++;
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		check_all(16'h0374);
		$display("reset value test done");
		wr(16'h0374, 32'h0080_0018);
		check_all(16'h0374);
		$display("init word test done");
		// reserved bits kept at their reset values on every write
		for (int i = 0; i < 8; i++) begin
			d = (i[2] ? 32'h0006_0086 : 32'h0086_0006) | (32'(i[1:0]) << 3);
			wr(16'h0374, d);
			check_all(16'h0374);
		end
		$display("power field test done");
		repeat (30) begin
			lfsr = nxt(lfsr);
			d = 32'h0006_0006 | {8'h00, lfsr[0], 15'h0000, lfsr[1], 2'h0, lfsr[3:2], 3'h0};
			wr(lfsr[4] ? 16'h0374 : {lfsr[15:5], 5'h01}, d);
			check_all(lfsr[6] ? 16'h0374 : {lfsr[15:7], 7'h03});
		end
		$display("random access test done");
		print_verdict();
	end
endmodule // tb
